// File: design/ross_pkg.sv
// Package for the relay output source selector: codes, bit positions, reset values
package ross_pkg;

  // ----------------------------------------------------------------
  // Register map (software port)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_FORCE_VALUES = 4'h0;
  localparam logic [3:0]  ADDR_FORCE_SELECT = 4'h1;
  localparam logic [3:0]  ADDR_RO4_SOURCE   = 4'h2;
  localparam logic [3:0]  ADDR_RO5_SOURCE   = 4'h3;
  localparam logic [3:0]  ADDR_OUT_STATE    = 4'h4;

  localparam logic [15:0] FORCE_VALUES_RST  = 16'h0000;
  localparam logic [15:0] FORCE_SELECT_RST  = 16'h0000;
  localparam logic [7:0]  SOURCE_RST        = 8'h00;

  // Bit positions in forced-values and force-select words
  localparam int          FRC_RO5_BIT       = 4;
  localparam int          FRC_DO1_BIT       = 5;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int MSW_READY_RUN  = 1;
  localparam int MSW_READY_REF  = 2;
  localparam int MSW_FAULT      = 3;
  localparam int MSW_WARNING    = 7;
  localparam int MSW_REMOTE     = 9;
  localparam int DSW1_STARTED   = 5;
  localparam int DSW1_RUNNING   = 6;
  localparam int DSW1_EXT2      = 11;
  localparam int DSW2_MAGNET    = 1;
  localparam int DSW2_ABOVE_LIM = 10;

  // ----------------------------------------------------------------
  // Selector codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_OFF        = 8'h00;
  localparam logic [7:0] SEL_ON         = 8'h01;
  localparam logic [7:0] SEL_READY_RUN  = 8'h02;
  localparam logic [7:0] SEL_STARTED    = 8'h05;
  localparam logic [7:0] SEL_MAGNET     = 8'h06;
  localparam logic [7:0] SEL_RUNNING    = 8'h07;
  localparam logic [7:0] SEL_READY_REF  = 8'h08;
  localparam logic [7:0] SEL_ABOVE_LIM  = 8'h0C;
  localparam logic [7:0] SEL_WARNING    = 8'h0D;
  localparam logic [7:0] SEL_FAULT      = 8'h0E;
  localparam logic [7:0] SEL_FAULT_N    = 8'h0F;
  localparam logic [7:0] SEL_FAULT_WARN = 8'h10;
  localparam logic [7:0] SEL_OVERCUR    = 8'h11;
  localparam logic [7:0] SEL_OVERVOLT   = 8'h12;
  localparam logic [7:0] SEL_DRV_TEMP   = 8'h13;
  localparam logic [7:0] SEL_UNDERVOLT  = 8'h14;
  localparam logic [7:0] SEL_MOT_TEMP   = 8'h15;
  localparam logic [7:0] SEL_EXT2       = 8'h17;
  localparam logic [7:0] SEL_REMOTE     = 8'h18;
  localparam logic [7:0] SEL_TIMED1     = 8'h1B;
  localparam logic [7:0] SEL_TIMED2     = 8'h1C;
  localparam logic [7:0] SEL_TIMED3     = 8'h1D;
  localparam logic [7:0] SEL_SUPV1      = 8'h21;
  localparam logic [7:0] SEL_SUPV2      = 8'h22;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] main_sw;
    logic [15:0] drv_sw1;
    logic [15:0] drv_sw2;
    logic [15:0] timed_sw;
    logic [15:0] supv_sw;
  } ross_status_t;

  // Fault-occurred flags, one per fault source
  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic undervoltage;
    logic igbt_overload;
    logic board_temp;
    logic igbt_overtemp;
    logic cooling;
    logic igbt_temp;
    logic excess_temp;
    logic excess_temp_diff;
    logic ext_temp1;
    logic ext_temp2;
  } ross_faults_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ross_bus_req_t;

endpackage

// File: design/ross_top.sv
// Relay output source selector, with force override of relay output five and digital output one
//
// Behaviour
// R1 - Hold a 16-bit forced-values word accepting any value 0000h to FFFFh.
// R2 - Fifth relay output takes its forced bit only when force-select enables it.
// R3 - First digital output takes its forced bit only when force-select enables it.
// R4 - Code 0 holds relay de-energized, code 1 holds it energized.
// R5 - Code 2 routes main status bit 1 ready-to-run; code 3 reserved.
// R6 - Started code routes drive status word 1 bit 5.
// R7 - Magnetized code routes drive status word 2 bit 1.
// R8 - Running code routes drive status word 1 bit 6.
// R9 - Ready-for-reference code routes main status bit 2.
// R10 - Code 12 routes drive status word 2 bit 10, above limit.
// R11 - Code 13 routes the warning flag, main status bit 7.
// R12 - Code 14 routes the fault flag, main status bit 3.
// R13 - Code 15 routes the inverted fault flag.
// R14 - Code 16 routes fault OR warning.
// R15 - Code 17 overcurrent fault, code 18 DC link overvoltage fault.
// R16 - Code 19 any of the seven drive temperature faults.
// R17 - Code 20 DC link undervoltage fault.
// R18 - Code 21 either external temperature fault; code 22 reserved.
// R19 - Code 23 routes second external place active, drive status word 1 bit 11.
// R20 - Code 24 routes remote control, main status bit 9.
// R21 - Codes 27 to 29 route timed-functions status bits 0 to 2.
// R22 - Codes 33 and 34 route supervision status bits 0 and 1.
// R23 - Code 6 magnetized, code 7 running, code 8 ready for reference.
// R24 - Reserved codes drive the relay output de-energized.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module ross_top
  import ross_pkg::*;
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_arst_n,
  input  wire ross_pkg::ross_bus_req_t i_bus,
  output logic [15:0]               o_rdata,
  input  wire ross_pkg::ross_status_t  i_status,
  input  wire ross_pkg::ross_faults_t  i_faults,
  output logic                      o_relay_output_four,
  output logic                      o_relay_output_five,
  output logic                      o_digital_output_one
);
  import ross_pkg::*;

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  // Fault flags are levels held by the fault logic outside, so a
  // selection follows them for as long as they stay set.

  // Any of the seven drive temperature faults
  function automatic logic drive_temp_any(input ross_faults_t fl);
    logic hit;
    hit = 1'b0;
    hit = hit | fl.igbt_overload;
    hit = hit | fl.board_temp;
    hit = hit | fl.igbt_overtemp;
    hit = hit | fl.cooling;
    hit = hit | fl.igbt_temp;
    hit = hit | fl.excess_temp;
    hit = hit | fl.excess_temp_diff;
    return hit;
  endfunction

  // Either external temperature fault
  function automatic logic ext_temp_any(input ross_faults_t fl);
    logic hit;
    hit = fl.ext_temp1 | fl.ext_temp2;
    return hit;
  endfunction

  // Forced bit when its enable is set, otherwise the normal level
  function automatic logic forced_level(
    input logic [15:0] sel,
    input logic [15:0] val,
    input int          pos,
    input logic        normal
  );
    logic lvl;
    lvl = normal;
    if (sel[pos])
    begin
      lvl = val[pos];
    end
    return lvl;
  endfunction

  // Level selected by a source code; unknown and reserved codes give 0
  function automatic logic src_level(
    input logic [7:0]   code,
    input ross_status_t st,
    input ross_faults_t fl
  );
    logic lvl;
    lvl = 1'b0;
    unique case (code)
      SEL_OFF        :
      begin
        lvl = 1'b0;                                                     // [R4]
      end
      SEL_ON         :
      begin
        lvl = 1'b1;                                                     // [R4]
      end
      SEL_READY_RUN  :
      begin
        lvl = st.main_sw[MSW_READY_RUN];                                // [R5]
      end
      SEL_STARTED    :
      begin
        lvl = st.drv_sw1[DSW1_STARTED];                                 // [R6]
      end
      SEL_MAGNET     :
      begin
        lvl = st.drv_sw2[DSW2_MAGNET];                                  // [R7] [R23]
      end
      SEL_RUNNING    :
      begin
        lvl = st.drv_sw1[DSW1_RUNNING];                                 // [R8] [R23]
      end
      SEL_READY_REF  :
      begin
        lvl = st.main_sw[MSW_READY_REF];                                // [R9] [R23]
      end
      SEL_ABOVE_LIM  :
      begin
        lvl = st.drv_sw2[DSW2_ABOVE_LIM];                               // [R10]
      end
      SEL_WARNING    :
      begin
        lvl = st.main_sw[MSW_WARNING];                                  // [R11]
      end
      SEL_FAULT      :
      begin
        lvl = st.main_sw[MSW_FAULT];                                    // [R12]
      end
      SEL_FAULT_N    :
      begin
        lvl = ~st.main_sw[MSW_FAULT];                                   // [R13]
      end
      SEL_FAULT_WARN :
      begin
        lvl = st.main_sw[MSW_FAULT] | st.main_sw[MSW_WARNING];          // [R14]
      end
      SEL_OVERCUR    :
      begin
        lvl = fl.overcurrent;                                           // [R15]
      end
      SEL_OVERVOLT   :
      begin
        lvl = fl.overvoltage;                                           // [R15]
      end
      SEL_DRV_TEMP   :
      begin
        lvl = drive_temp_any(fl);                                       // [R16]
      end
      SEL_UNDERVOLT  :
      begin
        lvl = fl.undervoltage;                                          // [R17]
      end
      SEL_MOT_TEMP   :
      begin
        lvl = ext_temp_any(fl);                                         // [R18]
      end
      SEL_EXT2       :
      begin
        lvl = st.drv_sw1[DSW1_EXT2];                                    // [R19]
      end
      SEL_REMOTE     :
      begin
        lvl = st.main_sw[MSW_REMOTE];                                   // [R20]
      end
      SEL_TIMED1     :
      begin
        lvl = st.timed_sw[0];                                           // [R21]
      end
      SEL_TIMED2     :
      begin
        lvl = st.timed_sw[1];                                           // [R21]
      end
      SEL_TIMED3     :
      begin
        lvl = st.timed_sw[2];                                           // [R21]
      end
      SEL_SUPV1      :
      begin
        lvl = st.supv_sw[0];                                            // [R22]
      end
      SEL_SUPV2      :
      begin
        lvl = st.supv_sw[1];                                            // [R22]
      end
      default        :
      begin
        lvl = 1'b0;                                                     // [R24]
      end
    endcase
    return lvl;
  endfunction

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Source registers keep only the low byte of a write; reads of an
  // unmapped address return zero, and read data stand for one cycle.
  logic [15:0] force_val_q;
  logic [15:0] force_val_d;
  logic [15:0] force_sel_q;
  logic [15:0] force_sel_d;
  logic [7:0]  ro4_src_q;
  logic [7:0]  ro4_src_d;
  logic [7:0]  ro5_src_q;
  logic [7:0]  ro5_src_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  always_comb
  begin
    force_val_d = force_val_q;
    force_sel_d = force_sel_q;
    ro4_src_d   = ro4_src_q;
    ro5_src_d   = ro5_src_q;
    rdata_d     = 16'h0000;
    if (i_bus.wr)
    begin
      unique case (i_bus.addr)
        ADDR_FORCE_VALUES :
        begin
          force_val_d = i_bus.wdata;                                    // [R1]
        end
        ADDR_FORCE_SELECT :
        begin
          force_sel_d = i_bus.wdata;
        end
        ADDR_RO4_SOURCE   :
        begin
          ro4_src_d = i_bus.wdata[7:0];
        end
        ADDR_RO5_SOURCE   :
        begin
          ro5_src_d = i_bus.wdata[7:0];
        end
        default           :
        begin
        end
      endcase
    end
    if (i_bus.rd)
    begin
      unique case (i_bus.addr)
        ADDR_FORCE_VALUES :
        begin
          rdata_d = force_val_q;                                        // [R1]
        end
        ADDR_FORCE_SELECT :
        begin
          rdata_d = force_sel_q;
        end
        ADDR_RO4_SOURCE   :
        begin
          rdata_d = {8'h00, ro4_src_q};
        end
        ADDR_RO5_SOURCE   :
        begin
          rdata_d = {8'h00, ro5_src_q};
        end
        ADDR_OUT_STATE    :
        begin
          // Registered outputs, so software sees what the loads see
          rdata_d = {13'h0000, o_digital_output_one, o_relay_output_five, o_relay_output_four};
        end
        default           :
        begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      force_val_q <= FORCE_VALUES_RST;
      force_sel_q <= FORCE_SELECT_RST;
      ro4_src_q   <= SOURCE_RST;
      ro5_src_q   <= SOURCE_RST;
      rdata_q     <= 16'h0000;
    end
    else
    begin
      force_val_q <= force_val_d;
      force_sel_q <= force_sel_d;
      ro4_src_q   <= ro4_src_d;
      ro5_src_q   <= ro5_src_d;
      rdata_q     <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  // Every output is registered so that a glitch on a status word
  // between edges never reaches a relay coil.
  // Digital output one has no source selector: unforced it stays off.
  logic ro4_d;
  logic ro5_d;
  logic do1_d;
  logic ro4_q;
  logic ro5_q;
  logic do1_q;
  logic ro5_norm;

  always_comb
  begin
    ro5_norm = src_level(ro5_src_q, i_status, i_faults);
    ro4_d    = src_level(ro4_src_q, i_status, i_faults);
    ro5_d    = forced_level(force_sel_q, force_val_q, FRC_RO5_BIT, ro5_norm); // [R2]
    do1_d    = forced_level(force_sel_q, force_val_q, FRC_DO1_BIT, 1'b0);     // [R3]
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ro4_q <= 1'b0;
      ro5_q <= 1'b0;
      do1_q <= 1'b0;
    end
    else
    begin
      ro4_q <= ro4_d;
      ro5_q <= ro5_d;
      do1_q <= do1_d;
    end
  end

  assign o_relay_output_four  = ro4_q;
  assign o_relay_output_five  = ro5_q;
  assign o_digital_output_one = do1_q;

endmodule // ross_top

// File: tb/ross_load_model.sv
// Relay contact and digital load model
`timescale 1ns/1ps
module ross_load_model
(
  input  wire logic       i_relay_four,
  input  wire logic       i_relay_five,
  input  wire logic       i_digital_one,
  output logic [2:0]      o_energized
);
  // Contacts close while the line is driven high
  assign o_energized = {i_digital_one, i_relay_five, i_relay_four};
endmodule // ross_load_model

// File: tb/ross_top_monitor.sv
// Checker for the relay output source selector
`timescale 1ns/1ps
module ross_top_monitor
  import ross_pkg::*;
(
  input wire logic                    i_ref_clk,
  input wire logic                    i_arst_n,
  input wire ross_pkg::ross_bus_req_t i_bus,
  input wire logic [15:0]             o_rdata,
  input wire ross_pkg::ross_status_t  i_status,
  input wire ross_pkg::ross_faults_t  i_faults,
  input wire logic                    o_relay_output_four,
  input wire logic                    o_relay_output_five,
  input wire logic                    o_digital_output_one
);
  logic [15:0] fv_q;
  logic [15:0] fs_q;
  logic [7:0]  s4_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // Shadow copies of the forced-values, force-select and relay four source registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      fv_q <= 16'h0000;
      fs_q <= 16'h0000;
      s4_q <= 8'h00;
    end
    else if (i_bus.wr)
    begin
      if (i_bus.addr == ADDR_FORCE_VALUES) fv_q <= i_bus.wdata;
      if (i_bus.addr == ADDR_FORCE_SELECT) fs_q <= i_bus.wdata;
      if (i_bus.addr == ADDR_RO4_SOURCE) s4_q <= i_bus.wdata[7:0];
    end
  sequence s_fv_read;
    i_bus.rd && i_bus.addr == ADDR_FORCE_VALUES;
  endsequence
  a_force_hold: assert property (s_fv_read |=> o_rdata == $past(fv_q)) else $error("forced word bad");
  a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 16'h0000) else $error("rdata not idle");
  a_ro4_off: assert property (s4_q == 8'h00 |=> !o_relay_output_four) else $error("code 0 bad");
  a_ro4_on: assert property (s4_q == 8'h01 |=> o_relay_output_four) else $error("code 1 bad");
  a_ro4_ready: assert property (s4_q == 8'h02 |=> o_relay_output_four == $past(i_status.main_sw[1]))
    else $error("code 2 bad");
  a_ro4_fault_n: assert property (s4_q == 8'h0F |=> o_relay_output_four != $past(i_status.main_sw[3]))
    else $error("code 15 bad");
  a_ro4_temp: assert property (s4_q == 8'h13 |=> o_relay_output_four == $past(|i_faults[8:2]))
    else $error("code 19 bad");
  a_ro4_reserved: assert property (s4_q inside {8'h03, 8'h16} |=> !o_relay_output_four)
    else $error("reserved code bad");
  a_ro5_forced: assert property (fs_q[4] |=> o_relay_output_five == $past(fv_q[4])) else $error("ro5 force bad");
  a_do1_forced: assert property (##1 o_digital_output_one == $past(fs_q[5] & fv_q[5])) else $error("do1 bad");
endmodule // ross_top_monitor

bind ross_top ross_top_monitor ross_top_monitor_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_status(i_status), .i_faults(i_faults), .o_relay_output_four(o_relay_output_four),
  .o_relay_output_five(o_relay_output_five), .o_digital_output_one(o_digital_output_one));

// File: tb/test_relay_output_source_select.sv
// Self-checking testbench for the relay output source selector
`timescale 1ns/1ps
module test_relay_output_source_select;
  import ross_pkg::*;
  logic          i_ref_clk = 1'b0;
  logic          i_arst_n  = 1'b0;
  ross_bus_req_t bus       = '0;
  ross_status_t  st        = '0;
  ross_faults_t  ft        = '0;
  logic [15:0]   rdata;
  logic          ro4, ro5, do1;
  logic [2:0]    load;
  int            failures  = 0;
  int            checks    = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  ross_top ross_top_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_bus(bus), .o_rdata(rdata), .i_status(st),
    .i_faults(ft), .o_relay_output_four(ro4), .o_relay_output_five(ro5), .o_digital_output_one(do1));
  ross_load_model ross_load_model_i (.i_relay_four(ro4), .i_relay_five(ro5), .i_digital_one(do1), .o_energized(load));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask
  function automatic logic exp_src(input logic [7:0] c);
    case (c)
      8'h01: return 1'b1;
      8'h02: return st.main_sw[1];
      8'h05: return st.drv_sw1[5];
      8'h06: return st.drv_sw2[1];
      8'h07: return st.drv_sw1[6];
      8'h08: return st.main_sw[2];
      8'h0C: return st.drv_sw2[10];
      8'h0D: return st.main_sw[7];
      8'h0E: return st.main_sw[3];
      8'h0F: return !st.main_sw[3];
      8'h10: return st.main_sw[3] | st.main_sw[7];
      8'h11: return ft.overcurrent;
      8'h12: return ft.overvoltage;
      8'h13: return |{ft.igbt_overload, ft.board_temp, ft.igbt_overtemp, ft.cooling, ft.igbt_temp, ft.excess_temp,
                      ft.excess_temp_diff};
      8'h14: return ft.undervoltage;
      8'h15: return ft.ext_temp1 | ft.ext_temp2;
      8'h17: return st.drv_sw1[11];
      8'h18: return st.main_sw[9];
      8'h1B, 8'h1C, 8'h1D: return st.timed_sw[c - 8'h1B];
      8'h21, 8'h22: return st.supv_sw[c - 8'h21];
      default: return 1'b0;
    endcase
  endfunction
  task automatic t_reset;
    logic [15:0] d;
    wr(4'h9, 16'hFFFF);
    for (int a = 0; a < 6; a++)
    begin
      rd(a[3:0] + ((a == 5) ? 4'h4 : 4'h0), d);
      chk(d, 16'h0000);
    end
    chk({13'h0000, load}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_force;
    logic [15:0] d;
    wr(ADDR_FORCE_VALUES, 16'hFFFF);
    rd(ADDR_FORCE_VALUES, d);
    chk(d, 16'hFFFF);
    wr(ADDR_FORCE_SELECT, 16'h0030);
    settle;
    chk({14'h0000, do1, ro5}, 16'h0003);
    wr(ADDR_FORCE_VALUES, 16'hFFCF);
    settle;
    chk({14'h0000, do1, ro5}, 16'h0000);
    wr(ADDR_FORCE_SELECT, 16'hFFCF);
    wr(ADDR_FORCE_VALUES, 16'h0030);
    wr(ADDR_RO5_SOURCE, 16'h0001);
    settle;
    rd(ADDR_OUT_STATE, d);
    chk(d, 16'h0002);
    wr(ADDR_FORCE_SELECT, 16'h0000);
    $display("test force done");
  endtask
  task automatic t_codes;
    for (int c = 0; c < 35; c++)
    begin
      wr(ADDR_RO4_SOURCE, 16'(c));
      wr(ADDR_RO5_SOURCE, 16'(c));
      for (int k = 0; k < 17; k++)
      begin
        @(posedge i_ref_clk);
        st <= {5{16'h0001 << k}};
        ft <= ross_faults_t'(12'h001 << k);
        settle;
        chk({14'h0000, load[1:0]}, {14'h0000, {2{exp_src(8'(c))}}});
      end
    end
    $display("test codes done");
  endtask
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #900000;
    failures++;
    print_verdict;
  end
  initial
  begin
    repeat (16) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    t_reset;
    t_force;
    t_codes;
    print_verdict;
  end
endmodule // test_relay_output_source_select
